// *** core/uart_spi_pkg.sv ***
package uart_spi_pkg;
    // ==========================================================
    // Transaction layout
    localparam int CMD_BITS   = 8;
    localparam int DATA_BITS  = 8;
    localparam int FRAME_BITS = CMD_BITS + DATA_BITS;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h0F;
    localparam logic [CNT_W-1:0] CMD_LAST   = 5'h07;
    // ==========================================================
    // Command byte fields
    localparam int CMD_REG_BIT   = 4;
    localparam int CMD_WRITE_BIT = 3;
    localparam int CMD_ADDR_MSB  = 2;
    localparam logic [2:0] CMD_TOP_ZERO = 3'h0;
    // ==========================================================
    // Host link clock divider: half period in enabled host clocks
    localparam logic [3:0] HOST_HALF_DIV = 4'h2;
    // Host interrupt pulse width in core clocks, long enough for a slow host
    localparam logic [3:0] IRQ_PULSE_LEN = 4'h8;
endpackage : uart_spi_pkg

// *** core/uart_spi_if.sv ***
`timescale 1ns/1ns
interface uart_spi_if;
    logic sck;
    logic port_select_n;
    logic sdi;
    logic sdo;
    logic sdoOe_n;
    logic irq_n;

    modport device (
        input  sck,
        input  port_select_n,
        input  sdi,
        output sdo,
        output sdoOe_n,
        output irq_n
    );
    modport host (
        output sck,
        output port_select_n,
        output sdi,
        input  sdo,
        input  sdoOe_n,
        input  irq_n
    );
endinterface : uart_spi_if

// *** core/uart_spi_device.sv ***
`timescale 1ns/1ns
// How it works
// - All host traffic crosses this serial link
// - Host lowers select, then clock low
// - Host keeps select low for whole frame
// - Short frame is discarded, except a read already issued
// - Write: command byte then data byte in
// - Read: command byte in, data byte out
// - Each frame is exactly sixteen bits
// - Host sets input before rising edge
// - Input sampled on rising clock edges
// - Output changes on falling clock edges
// - Host captures output before next fall
// - Deselected: port idle, output released
// - Host raises select between frames
// - Write executes after frame and deselect
// - Read acts after eighth command bit
// - Select high anytime aborts the frame
// - Module raises own interrupt to host
// - Command: zero top, reg, write, address
// - Interrupt is a low pulse
module uart_spi_device
    import uart_spi_pkg::*;
(
    input  wire logic        module_core_clock_in,
    input  wire logic        nrst,
    input  wire logic        clkEn,
    uart_spi_if.device       link,
    output      logic        wrStrobe,
    output      logic        wrIsReg,
    output      logic [2:0]  wrAddr,
    output      logic [7:0]  wrData,
    output      logic        rdStrobe,
    output      logic        rdIsReg,
    output      logic [2:0]  rdAddr,
    input  wire logic [7:0]  rdData,
    input  wire logic        uartEvent
);
    // ==========================================================
    // Link domain, clocked by sck, cleared by select high
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [15:0]      shift;
        logic             full;
    } rise_t;
    // Handed to the core domain; survives deselect, cleared by core reset
    typedef struct packed {
        logic        rdTog;
        logic [4:0]  rdCmd;
        logic        frameTog;
        logic [15:0] frameHold;
    } keep_t;
    rise_t rs, next_rs;
    keep_t ks, next_ks;
    logic  sdoBit;
    logic  txBusy;
    logic [7:0] txShift;

    always_comb begin
        next_rs = rs;
        next_ks = ks;
        if (!rs.full) begin
            next_rs.shift = {rs.shift[14:0], link.sdi};
            next_rs.cnt   = rs.cnt + 5'h01;
            if (rs.cnt == FRAME_LAST) begin
                next_rs.full      = 1'b1;
                next_ks.frameTog  = ~ks.frameTog;
                next_ks.frameHold = next_rs.shift;
            end
            if (rs.cnt == CMD_LAST
                && next_rs.shift[7:5] == CMD_TOP_ZERO
                && !next_rs.shift[CMD_WRITE_BIT]) begin
                next_ks.rdTog = ~ks.rdTog;
                next_ks.rdCmd = next_rs.shift[4:0];
            end
        end
    end

    // Async clear by select keeps every frame starting at the command
    always_ff @(posedge link.sck or posedge link.port_select_n) begin
        if (link.port_select_n) begin
            rs <= '0;
        end else begin
            rs <= next_rs;
        end
    end

    // Only a complete frame toggles frameTog; a cut frame still keeps a read issued after the eighth bit
    always_ff @(posedge link.sck or negedge nrst) begin
        if (!nrst) begin
            ks <= '0;
        end else if (!link.port_select_n) begin
            ks <= next_ks;
        end
    end

    // Read data is sampled once in the falling domain after command
    always_ff @(negedge link.sck or posedge link.port_select_n) begin
        if (link.port_select_n) begin
            txBusy  <= 1'b0;
            txShift <= '0;
            sdoBit  <= 1'b0;
        end else if (rs.cnt == 5'h08 && !txBusy) begin
            txBusy  <= 1'b1;
            txShift <= {rdData[6:0], 1'b0};
            sdoBit  <= rdData[7];
        end else if (txBusy) begin
            sdoBit  <= txShift[7];
            txShift <= {txShift[6:0], 1'b0};
        end
    end

    assign link.sdo     = sdoBit;
    assign link.sdoOe_n = link.port_select_n | ~txBusy;

    // ==========================================================
    // Core domain
    typedef struct packed {
        logic [1:0] selSync;
        logic [2:0] fullSync;
        logic [2:0] rdSync;
        logic       fullSeen;
        logic       wrStrobe;
        logic       wrIsReg;
        logic [2:0] wrAddr;
        logic [7:0] wrData;
        logic       rdStrobe;
        logic       rdIsReg;
        logic [2:0] rdAddr;
        logic [15:0] frame;
        logic       evtLast;
        logic [3:0] irqCnt;
    } core_t;
    core_t cs, next_cs;

    always_comb begin
        next_cs          = cs;
        next_cs.wrStrobe = 1'b0;
        next_cs.rdStrobe = 1'b0;
        next_cs.selSync  = {cs.selSync[0], link.port_select_n};
        next_cs.fullSync = {cs.fullSync[1:0], ks.frameTog};
        next_cs.rdSync   = {cs.rdSync[1:0], ks.rdTog};
        next_cs.evtLast  = uartEvent;
        if (cs.selSync[1]) begin
            if (cs.fullSeen && cs.frame[15:13] == CMD_TOP_ZERO
                && cs.frame[8 + CMD_WRITE_BIT]) begin
                next_cs.wrStrobe = 1'b1;
                next_cs.wrIsReg  = cs.frame[8 + CMD_REG_BIT];
                next_cs.wrAddr   = cs.frame[10:8];
                next_cs.wrData   = cs.frame[7:0];
            end
            next_cs.fullSeen = 1'b0;
        end
        // Held frame is stable once its toggle is seen; a new frame wins
        if (cs.fullSync[2] != cs.fullSync[1]) begin
            next_cs.fullSeen = 1'b1;
            next_cs.frame    = ks.frameHold;
        end
        if (cs.rdSync[2] != cs.rdSync[1]) begin
            next_cs.rdStrobe = 1'b1;
            next_cs.rdIsReg  = ks.rdCmd[CMD_REG_BIT];
            next_cs.rdAddr   = ks.rdCmd[2:0];
        end
        if (cs.irqCnt != 4'h0) begin
            next_cs.irqCnt = cs.irqCnt - 4'h1;
        end
        if (uartEvent && !cs.evtLast) begin
            next_cs.irqCnt = IRQ_PULSE_LEN;
        end
    end

    always_ff @(posedge module_core_clock_in or negedge nrst) begin
        if (!nrst) begin
            cs         <= '0;
            cs.selSync <= 2'h3;
        end else if (clkEn) begin
            cs <= next_cs;
        end
    end

    assign wrStrobe   = cs.wrStrobe;
    assign wrIsReg    = cs.wrIsReg;
    assign wrAddr     = cs.wrAddr;
    assign wrData     = cs.wrData;
    assign rdStrobe   = cs.rdStrobe;
    assign rdIsReg    = cs.rdIsReg;
    assign rdAddr     = cs.rdAddr;
    assign link.irq_n = cs.irqCnt == 4'h0;
endmodule : uart_spi_device

// *** core/uart_spi_host.sv ***
`timescale 1ns/1ns
module uart_spi_host
    import uart_spi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       clkEn,
    uart_spi_if.host        link,
    input  wire logic       reqValid,
    output      logic       reqReady,
    input  wire logic [7:0] reqCmd,
    input  wire logic [7:0] reqData,
    output      logic       rspValid,
    output      logic [7:0] rspData,
    output      logic       irqPulse
);
    typedef enum logic [1:0] {
        IDLE  = 2'b00,
        SETUP = 2'b01,
        SHIFT = 2'b11,
        GAP   = 2'b10
    } state_t;

    typedef struct packed {
        state_t     st;
        logic [3:0] div;
        logic [4:0] bitCnt;
        logic [15:0] txSh;
        logic [7:0] rxSh;
        logic       sck;
        logic       sel_n;
        logic       rspValid;
        logic [7:0] rspData;
        logic [2:0] irqSync;
    } host_t;
    host_t hs, next_hs;
    logic tick;

    assign tick = hs.div == HOST_HALF_DIV - 4'h1;

    always_comb begin
        next_hs          = hs;
        next_hs.rspValid = 1'b0;
        next_hs.irqSync  = {hs.irqSync[1:0], link.irq_n};
        next_hs.div      = tick ? 4'h0 : hs.div + 4'h1;
        unique case (hs.st)
            IDLE: begin
                next_hs.div = 4'h0;
                if (reqValid) begin
                    next_hs.st     = SETUP;
                    next_hs.sel_n  = 1'b0;
                    next_hs.txSh   = {reqCmd, reqData};
                    next_hs.bitCnt = '0;
                end
            end
            SETUP: if (tick) begin
                next_hs.st = SHIFT;
            end
            SHIFT: if (tick) begin
                if (!hs.sck) begin
                    next_hs.sck  = 1'b1;
                    next_hs.rxSh = {hs.rxSh[6:0], link.sdo};
                end else begin
                    next_hs.sck    = 1'b0;
                    next_hs.txSh   = {hs.txSh[14:0], 1'b0};
                    next_hs.bitCnt = hs.bitCnt + 5'h01;
                    if (hs.bitCnt == FRAME_LAST) begin
                        next_hs.st       = GAP;
                        next_hs.sel_n    = 1'b1;
                        next_hs.rspValid = 1'b1;
                        next_hs.rspData  = hs.rxSh;
                    end
                end
            end
            GAP: if (tick) begin
                next_hs.st = IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hs         <= '0;
            hs.sel_n   <= 1'b1;
            hs.irqSync <= 3'h7;
        end else if (clkEn) begin
            hs <= next_hs;
        end
    end

    assign link.sck           = hs.sck;
    assign link.port_select_n = hs.sel_n;
    assign link.sdi           = hs.txSh[15];
    assign reqReady           = hs.st == IDLE;
    assign rspValid           = hs.rspValid;
    assign rspData            = hs.rspData;
    assign irqPulse           = hs.irqSync[2] & ~hs.irqSync[1];
endmodule : uart_spi_host

// *** test/uart_spi_monitor.sv ***
`timescale 1ns/1ns
module uart_spi_monitor (
    input wire logic clk,
    input wire logic module_core_clock_in,
    input wire logic nrst,
    input wire logic sck,
    input wire logic port_select_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdoOe_n,
    input wire logic irq_n
);
    // ==========
    // Link clock rises seen in the current frame
    logic [4:0] rises;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rises <= 5'h00;
        end else if (port_select_n) begin
            rises <= 5'h00;
        end else if ($rose(sck)) begin
            rises <= rises + 5'h01;
        end
    end
    sequence sSetup;
        !sck ##1 !sck;
    endsequence
    sequence sLowPulse;
        !irq_n [*7] ##1 irq_n;
    endsequence
    // ==========
    a_sdo_released: assert property (@(posedge clk) disable iff (!nrst)
        port_select_n && $past(port_select_n) |-> sdoOe_n)
        else $error("sdo driven while deselected");
    a_sdo_on_fall: assert property (@(posedge clk) disable iff (!nrst)
        !sdoOe_n && $past(!sdoOe_n) && $changed(sdo) |-> $fell(sck))
        else $error("sdo changed away from a falling edge");
    a_data_phase: assert property (@(posedge clk) disable iff (!nrst)
        !sdoOe_n && !port_select_n |-> rises >= 5'h08)
        else $error("sdo driven during the command phase");
    a_sck_idle: assert property (@(posedge clk) disable iff (!nrst)
        port_select_n |-> !sck)
        else $error("link clock moving outside a frame");
    a_frame_len: assert property (@(posedge clk) disable iff (!nrst)
        $rose(port_select_n) |-> rises == 5'h10)
        else $error("frame ended without sixteen clocks");
    a_host_setup: assert property (@(posedge clk) disable iff (!nrst)
        $fell(port_select_n) |-> sSetup)
        else $error("link clock rose right after select");
    a_sdi_settled: assert property (@(posedge clk) disable iff (!nrst)
        $rose(sck) |-> $stable(sdi))
        else $error("sdi moved at a rising edge");
    a_irq_pulse: assert property (@(posedge module_core_clock_in)
        disable iff (!nrst) $fell(irq_n) |=> sLowPulse)
        else $error("interrupt pulse width wrong");
endmodule : uart_spi_monitor

// *** test/uart_module_spi_slave_port_test.sv ***
`timescale 1ns/1ns
module uart_module_spi_slave_port_test;
    import uart_spi_pkg::*;
    logic clk = 1'b0, coreClk = 1'b0, nrst = 1'b1, hostEn = 1'b0;
    logic reqValid = 1'b0, uartEvent = 1'b0, reqReady, rspValid, irqPulse;
    logic [7:0] reqCmd = 8'h00, reqData = 8'h00, rspData, rdData, gotData;
    logic wrStrobe, wrIsReg, rdStrobe, rdIsReg, wrStrobeB;
    logic [7:0] wrData;
    logic [2:0] wrAddr, rdAddr;
    logic [1:0] divCnt = 2'h0;
    logic [11:0] wrLast, rdLast, dWr, dRd;
    int failures = 0, check_count = 0, cycles = 0;
    int wrSeen = 0, rdSeen = 0, wrSeenB = 0;
    uart_spi_if link ();
    uart_spi_if linkB ();
    uart_spi_host u_uart_spi_host (.clk(clk), .nrst(nrst), .clkEn(hostEn),
        .link(link), .reqValid(reqValid), .reqReady(reqReady),
        .reqCmd(reqCmd), .reqData(reqData), .rspValid(rspValid),
        .rspData(rspData), .irqPulse(irqPulse));
    uart_spi_device u_uart_spi_device (.module_core_clock_in(coreClk),
        .nrst(nrst), .clkEn(1'b1), .link(link), .wrStrobe(wrStrobe),
        .wrIsReg(wrIsReg), .wrAddr(wrAddr), .wrData(wrData),
        .rdStrobe(rdStrobe), .rdIsReg(rdIsReg), .rdAddr(rdAddr),
        .rdData(rdData), .uartEvent(uartEvent));
    uart_spi_device u_uart_spi_device_b (.module_core_clock_in(coreClk),
        .nrst(nrst), .clkEn(1'b1), .link(linkB), .wrStrobe(wrStrobeB),
        .wrIsReg(), .wrAddr(), .wrData(), .rdStrobe(), .rdIsReg(),
        .rdAddr(), .rdData(8'h00), .uartEvent(1'b0));
    uart_spi_monitor u_uart_spi_monitor (.clk(clk),
        .module_core_clock_in(coreClk), .nrst(nrst), .sck(link.sck),
        .port_select_n(link.port_select_n), .sdi(link.sdi), .sdo(link.sdo),
        .sdoOe_n(link.sdoOe_n), .irq_n(link.irq_n));
    // ==========
    // Clocks, host slow-down enable, core answers and strobe capture
    always #50 clk = ~clk;
    always begin
        #63 coreClk = ~coreClk;
        #62 coreClk = ~coreClk;
    end
    always @(negedge clk) begin
        divCnt <= divCnt + 2'h1;
        hostEn <= (divCnt == 2'h3);
    end
    assign rdData = rdIsReg ? {5'h0A, rdAddr} : 8'h5C;
    always @(negedge coreClk) begin
        if (wrStrobe === 1'b1) begin
            wrSeen++;
            wrLast = {wrIsReg, wrAddr, wrData};
            if (link.port_select_n !== 1'b1) fail("write before deselect");
        end
        if (rdStrobe === 1'b1) begin
            rdSeen++;
            rdLast = {8'h00, rdIsReg, rdAddr};
        end
        if (wrStrobeB === 1'b1) wrSeenB++;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail("timeout");
            final_report();
        end
    end
    // ==========
    task automatic fail(input string msg);
        $display("FAIL %0t %s", $time, msg);
        failures++;
    endtask : fail
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) fail("value mismatch");
    endtask : chk
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] data);
        int n, w0, r0;
        w0 = wrSeen;
        r0 = rdSeen;
        @(negedge clk);
        reqCmd = cmd;
        reqData = data;
        reqValid = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(reqReady === 1'b1 && hostEn === 1'b1) && n < 100);
        if (n == 100) fail("request not taken");
        @(negedge clk) reqValid = 1'b0;
        n = 0;
        do begin @(posedge clk); n++; end while (rspValid !== 1'b1 && n < 2000);
        if (n == 2000) fail("no response");
        gotData = rspData;
        repeat (20) @(posedge clk);
        dWr = 12'(wrSeen - w0);
        dRd = 12'(rdSeen - r0);
    endtask : xfer
    task automatic raw_frame(input int bits, input logic [15:0] pat);
        linkB.port_select_n = 1'b0;
        for (int i = 0; i < bits; i++) begin
            linkB.sdi = pat[15-i];
            #63 linkB.sck = 1'b1;
            #62 linkB.sck = 1'b0;
        end
        #63 linkB.port_select_n = 1'b1;
        linkB.sdi = ~linkB.sdi;
        #2000;
    endtask : raw_frame
    task automatic final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    // ==========
    initial begin
        linkB.sck = 1'b0;
        linkB.port_select_n = 1'b1;
        linkB.sdi = 1'b0;
        @(negedge clk) nrst = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        for (int a = 0; a < 8; a++) begin
            xfer({5'h03, a[2:0]}, 8'hC0 | 8'(a));
            chk(dWr, 12'h001);
            chk(wrLast, {1'b1, a[2:0], 8'hC0 | 8'(a)});
            xfer({5'h02, a[2:0]}, 8'h00);
            chk(dRd, 12'h001);
            chk(rdLast, {9'h001, a[2:0]});
            chk({4'h0, gotData}, {9'h00A, a[2:0]});
        end
        $display("register access test done");
        xfer(8'h0D, 8'h3C);
        chk({3'h0, wrLast[11], wrLast[7:0]}, 12'h03C);
        xfer(8'h05, 8'h00);
        chk({4'h0, gotData}, 12'h05C);
        chk({8'h00, rdLast[3:0]} & 12'h008, 12'h000);
        xfer(8'h38, 8'h11);
        chk(dWr, 12'h000);
        xfer(8'hB2, 8'h00);
        chk(dRd, 12'h000);
        $display("fifo and refused command test done");
        raw_frame(15, 16'h1BA5);
        chk(12'(wrSeenB), 12'h000);
        raw_frame(9, 16'h1BA5);
        chk(12'(wrSeenB), 12'h000);
        raw_frame(16, 16'h1BA5);
        chk(12'(wrSeenB), 12'h001);
        $display("abort test done");
        @(negedge clk) uartEvent = 1'b1;
        for (int n = 0; n < 100 && irqPulse !== 1'b1; n++) @(negedge clk);
        chk({11'h000, irqPulse}, 12'h001);
        @(negedge clk) uartEvent = 1'b0;
        $display("interrupt test done");
        final_report();
    end
endmodule : uart_module_spi_slave_port_test
